// ===== logic/irq_bank_pkg.sv
// constants, field positions and carriers of the interrupt register bank
// assumes one system clock; the core and event sources share it
package irq_bank_pkg;

    // register addresses on the plain register port
    localparam logic [2:0] ADDR_EDGE   = 3'h0; // pin_edge_select
    localparam logic [2:0] ADDR_CTRL0  = 3'h1; // primary_irq_ctrl_0
    localparam logic [2:0] ADDR_CTRL1  = 3'h2; // primary_irq_ctrl_1
    localparam logic [2:0] ADDR_GRP0   = 3'h3; // shared_group_ctrl_0
    localparam logic [2:0] ADDR_GRP1   = 3'h4; // shared_group_ctrl_1
    localparam logic [2:0] ADDR_STAT   = 3'h5; // overrun status, write 1 clears
    localparam logic [2:0] ADDR_MASK   = 3'h6; // overrun interrupt mask

    // reset values
    localparam logic [7:0] RST_VAL     = 8'h00;

    // implemented-bit masks
    localparam logic [7:0] EDGE_MASK_1 = 8'h03; // one external pin
    localparam logic [7:0] EDGE_MASK_2 = 8'h0F; // two external pins
    localparam logic [7:0] CTRL0_MASK  = 8'h7F;
    localparam logic [7:0] CTRL1_MASK  = 8'h77; // no upper source
    localparam logic [7:0] CTRL1_MASKX = 8'hFF; // with upper source
    localparam logic [7:0] GRP_MASK    = 8'h33;
    localparam logic [7:0] SRC_MASK    = 8'h7F;

    // field positions
    localparam int GLB_EN_BIT  = 0;  // global_irq_enable
    localparam int FLAG_LO     = 4;  // first flag bit of a control register
    localparam int EN_LO       = 0;  // first enable bit of a group register
    localparam int PIN0_SEL_LO = 0;  // pin0_edge_sel_lo
    localparam int PIN1_SEL_LO = 2;  // pin1_edge_sel_lo

    // edge-select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // source indices, lowest index has highest priority
    localparam int SRC_PIN0 = 0;
    localparam int SRC_TB0  = 1;
    localparam int SRC_TB1  = 2;
    localparam int SRC_GRP0 = 3;
    localparam int SRC_EEP  = 4;
    localparam int SRC_ADC  = 5;
    localparam int SRC_HI   = 6;
    localparam int NUM_SRC  = 7;

    // one-cycle event pulses from the on-chip sources
    typedef struct packed {
        logic       tb0;    // time base 0 tick
        logic       tb1;    // time base 1 tick
        logic       adc;    // conversion done
        logic       eeprom; // write done
        logic [1:0] tm0;    // timer 0 matches: [1] A, [0] P
        logic [1:0] tm1;    // timer 1 matches: [1] A, [0] P
    } src_evt_t;

    // request towards the core
    typedef struct packed {
        logic       req;    // a source may be vectored
        logic [2:0] vector; // index of the winning source
    } irq_out_t;

endpackage : irq_bank_pkg

// ===== logic/mcu_irq_register_bank.sv
// interrupt enable and request-flag register bank of a small controller
// assumes the core, event sources and register port run on clk;
// external pins are asynchronous and are synchronised here
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - pin0 edge field bits 1:0, four codes
// - pin1 edge field bits 3:2, same codes
// - bit 0 of control 0 is global enable
// - time base 1 flag bit6, enable bit3
// - time base 0 flag bit5, enable bit2
// - external pin flag bit4, enable bit1
// - converter flag bit6, enable bit2, control 1
// - eeprom flag bit5, enable bit1, control 1
// - group 0 flag bit4, enable bit0
// - unimplemented bits read back as zero
// - each source has enable and flag
// - timer match bits in separate group registers
// - events set flags; vector needs both enables
// - servicing clears global enable and the serviced flag
module mcu_irq_register_bank #(
    parameter bit HAS_PIN1   = 1'b0, // second external pin variant
    parameter bit HAS_GROUP1 = 1'b0  // second group register variant
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,    // freezes all state
    input  wire logic [2:0]              addr,      // register address
    input  wire logic [7:0]              wdata,     // write data
    input  wire logic                    wr_stb,    // write strobe
    input  wire logic                    rd_stb,    // read strobe
    output logic [7:0]                   rdata,     // read data, next cycle
    input  wire logic                    pin0_in,   // asynchronous pin 0
    input  wire logic                    pin1_in,   // asynchronous pin 1
    input  wire irq_bank_pkg::src_evt_t  events,    // source pulses
    input  wire logic                    irq_ack,   // core takes vector
    output irq_bank_pkg::irq_out_t       irq_out,   // request and vector
    output logic                         irq_line   // overrun interrupt
);
    import irq_bank_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    localparam bit         HI_IMPL  = HAS_PIN1 | HAS_GROUP1;
    localparam logic [7:0] EDGE_M   = HAS_PIN1 ? EDGE_MASK_2 : EDGE_MASK_1;
    localparam logic [7:0] CTRL1_M  = HI_IMPL ? CTRL1_MASKX : CTRL1_MASK;

    logic [7:0]         edge_reg;      // pin_edge_select
    logic [7:0]         ctrl0_reg;     // primary_irq_ctrl_0
    logic [7:0]         ctrl1_reg;     // primary_irq_ctrl_1
    logic [7:0]         grp0_reg;      // shared_group_ctrl_0
    logic [7:0]         grp1_reg;      // shared_group_ctrl_1
    logic [7:0]         stat_reg;      // overrun sticky bits
    logic [7:0]         mask_reg;      // overrun mask
    logic [7:0]         ctrl0_next;
    logic [7:0]         ctrl1_next;
    logic [7:0]         grp0_next;
    logic [7:0]         grp1_next;
    logic [7:0]         stat_next;
    logic [1:0]         pin_meta_reg;  // first synchroniser stage
    logic [1:0]         pin_sync_reg;  // second synchroniser stage
    logic [1:0]         pin_prev_reg;  // previous synchronised level
    logic               pin0_hit;      // selected edge seen on pin 0
    logic               pin1_hit;      // selected edge seen on pin 1
    logic               grp0_evt;      // enabled match in group 0
    logic               grp1_evt;      // enabled match in group 1
    logic               hi_evt;        // upper source of control 1
    logic [NUM_SRC-1:0] src_set;       // event per source
    logic [NUM_SRC-1:0] src_flag;      // flag per source
    logic [NUM_SRC-1:0] src_en;        // enable per source
    logic [NUM_SRC-1:0] pend_next;     // flag and enable, next state
    logic [NUM_SRC-1:0] ack_clr;       // flag cleared by service
    logic               ack_take;      // service accepted
    logic               wr_ctrl0;      // write hits control 0
    irq_out_t           irq_next;
    default clocking cb @(posedge clk); endclocking // checks sample on clk
    default disable iff (rst);                      // checks idle in reset

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // decides whether the selected edge occurred
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       cur,
                                      input logic       prev);
        case (sel)
            EDGE_RISE: edge_hit = cur & ~prev;
            EDGE_FALL: edge_hit = ~cur & prev;
            EDGE_BOTH: edge_hit = cur ^ prev;
            default:   edge_hit = 1'b0;  // edge detection off
        endcase
    endfunction : edge_hit

    // lowest pending index wins
    function automatic logic [2:0] prio_vec(input logic [NUM_SRC-1:0] p);
        prio_vec = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                prio_vec = 3'(i);
            end
        end
    endfunction : prio_vec

    ////////////////////////////////////////////////////////////////////////
    // external pin synchroniser and edge detection
    // two stages before any logic looks at the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pin_prev_reg <= 2'h0;
        end else if (clk_en) begin
            pin_meta_reg <= {pin1_in, pin0_in};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // edge codes steer the pin events
    assign pin0_hit = edge_hit(edge_reg[PIN0_SEL_LO +: 2],
                               pin_sync_reg[0], pin_prev_reg[0]);
    assign pin1_hit = HAS_PIN1 &
                      edge_hit(edge_reg[PIN1_SEL_LO +: 2],
                               pin_sync_reg[1], pin_prev_reg[1]);

    ////////////////////////////////////////////////////////////////////////
    // source map
    // a group event is a match whose own enable is set
    assign grp0_evt = |(events.tm0 & grp0_reg[EN_LO +: 2]);
    assign grp1_evt = HAS_GROUP1 & (|(events.tm1 & grp1_reg[EN_LO +: 2]));
    // upper bit pair of control 1 belongs to pin 1 when present, else to group 1
    assign hi_evt   = HAS_PIN1 ? pin1_hit : grp1_evt;

    // every source has its own flag and enable
    assign src_set  = {hi_evt, events.adc, events.eeprom, grp0_evt,
                       events.tb1, events.tb0, pin0_hit};
    assign src_flag = {ctrl1_reg[7:4], ctrl0_reg[6:4]};
    assign src_en   = {ctrl1_reg[3:0], ctrl0_reg[3:1]};

    // service accepted only while a request is shown
    assign ack_take = irq_ack & irq_out.req;
    assign ack_clr  = ack_take ? 7'(7'h01 << irq_out.vector) : 7'h00;
    assign wr_ctrl0 = wr_stb & (addr == ADDR_CTRL0);

    ////////////////////////////////////////////////////////////////////////
    // next values of the primary control registers
    // order: service clear, then software write, then hardware set
    always_comb begin
        // serviced source drops its flag
        ctrl0_next = ctrl0_reg & ~{1'b0, ack_clr[2:0], 4'h0};
        ctrl1_next = ctrl1_reg & ~{ack_clr[6:3], 4'h0};
        // servicing blocks nesting
        if (ack_take) begin
            ctrl0_next[GLB_EN_BIT] = 1'b0;
        end
        // software writes implemented bits only
        if (wr_ctrl0) begin
            ctrl0_next = wdata & CTRL0_MASK;
        end
        if (wr_stb && addr == ADDR_CTRL1) begin
            ctrl1_next = wdata & CTRL1_M;
        end
        // events set their flags and win over any clear
        ctrl0_next[FLAG_LO +: 3] = ctrl0_next[FLAG_LO +: 3] |
                                   src_set[2:0];
        ctrl1_next[FLAG_LO +: 4] = ctrl1_next[FLAG_LO +: 4] |
                                   (src_set[6:3] & {HI_IMPL, 3'h7});
    end

    // primary control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl0_reg <= RST_VAL;
            ctrl1_reg <= RST_VAL;
        end else if (clk_en) begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
        end
    end

    // edge-select register
    always_ff @(posedge clk) begin
        if (rst) begin
            edge_reg <= RST_VAL;
        end else if (clk_en && wr_stb && addr == ADDR_EDGE) begin
            edge_reg <= wdata & EDGE_M;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // group registers holding timer match bits
    // flags at 5:4 set by matches, enables at 1:0
    always_comb begin
        grp0_next = grp0_reg;
        grp1_next = grp1_reg;
        if (wr_stb && addr == ADDR_GRP0) begin
            grp0_next = wdata & GRP_MASK;
        end
        if (wr_stb && addr == ADDR_GRP1 && HAS_GROUP1) begin
            grp1_next = wdata & GRP_MASK;
        end
        grp0_next[FLAG_LO +: 2] = grp0_next[FLAG_LO +: 2] | events.tm0;
        if (HAS_GROUP1) begin
            grp1_next[FLAG_LO +: 2] = grp1_next[FLAG_LO +: 2] | events.tm1;
        end
    end

    // group register storage
    always_ff @(posedge clk) begin
        if (rst) begin
            grp0_reg <= RST_VAL;
            grp1_reg <= RST_VAL;
        end else if (clk_en) begin
            grp0_reg <= grp0_next;
            grp1_reg <= grp1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request towards the core
    // built from next state so a taken request drops at once
    assign pend_next = {ctrl1_next[7:4], ctrl0_next[6:4]} &
                       {ctrl1_next[3:0], ctrl0_next[3:1]};
    always_comb begin
        irq_next.req    = ctrl0_next[GLB_EN_BIT] & (|pend_next);
        irq_next.vector = prio_vec(pend_next);
    end

    // registered request and vector
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_out <= '0;
        end else if (clk_en) begin
            irq_out <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overrun status, mask and interrupt line
    // an event arriving on a set flag is recorded; set beats clear
    always_comb begin
        stat_next = stat_reg;
        if (wr_stb && addr == ADDR_STAT) begin
            stat_next = stat_reg & ~wdata;
        end
        stat_next = (stat_next | {1'b0, src_set & src_flag}) & SRC_MASK;
    end

    // status and mask storage
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_reg <= RST_VAL;
            mask_reg <= RST_VAL;
        end else if (clk_en) begin
            stat_reg <= stat_next;
            if (wr_stb && addr == ADDR_MASK) begin
                mask_reg <= wdata & SRC_MASK;
            end
        end
    end

    // level output while an unmasked overrun is set
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_line <= 1'b0;
        end else if (clk_en) begin
            irq_line <= |(stat_next & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    // data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= 8'h00;
            if (rd_stb) begin
                case (addr)
                    ADDR_EDGE:  rdata <= edge_reg;
                    ADDR_CTRL0: rdata <= ctrl0_reg;
                    ADDR_CTRL1: rdata <= ctrl1_reg;
                    ADDR_GRP0:  rdata <= grp0_reg;
                    ADDR_GRP1:  rdata <= grp1_reg;
                    ADDR_STAT:  rdata <= stat_reg;
                    ADDR_MASK:  rdata <= mask_reg;
                    default:    rdata <= 8'h00; // unmapped reads zero
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rise0;
        clk_en && edge_reg[1:0] == EDGE_RISE &&
        pin_sync_reg[0] && !pin_prev_reg[0];
    endsequence
    sequence s_service;
        clk_en && irq_ack && irq_out.req && !wr_ctrl0;
    endsequence
    a_pin0_rise_flag: assert property (s_rise0 |=> ctrl0_reg[4])
        else $error("pin0 rising edge did not set flag");
    a_pin1_fall_flag: assert property (
        clk_en && HAS_PIN1 && edge_reg[3:2] == EDGE_FALL &&
        !pin_sync_reg[1] && pin_prev_reg[1] |=> ctrl1_reg[7])
        else $error("pin1 falling edge did not set flag");
    a_global_off_quiet: assert property (
        clk_en && !ctrl0_reg[GLB_EN_BIT] && !wr_ctrl0 |=> !irq_out.req)
        else $error("request raised with global enable low");
    a_tb1_event_flag: assert property (
        clk_en && events.tb1 |=> ctrl0_reg[6])
        else $error("time base 1 flag not set");
    a_tb0_event_flag: assert property (
        clk_en && events.tb0 |=> ctrl0_reg[5])
        else $error("time base 0 flag not set");
    a_adc_event_flag: assert property (
        clk_en && events.adc |=> ctrl1_reg[6])
        else $error("converter flag not set");
    a_eep_event_flag: assert property (
        clk_en && events.eeprom |=> ctrl1_reg[5])
        else $error("eeprom flag not set");
    a_grp0_event_flag: assert property (
        clk_en && (|(events.tm0 & grp0_reg[1:0])) |=> ctrl1_reg[4])
        else $error("group 0 flag not set");
    a_rsvd_read_zero: assert property (
        clk_en && rd_stb && (addr == ADDR_CTRL0 || addr == ADDR_GRP0)
        |=> !rdata[7] && ($past(addr) == ADDR_CTRL0 ||
                          (rdata & ~GRP_MASK) == 8'h00))
        else $error("unimplemented bit read as one");
    a_service_blocks: assert property (
        s_service |=> !ctrl0_reg[GLB_EN_BIT] && !irq_out.req)
        else $error("global enable survived service");

endmodule : mcu_irq_register_bank

// ===== bench/core_ack_model.sv
// core model: takes a standing request after a chosen number of cycles
// assumes irq_out is registered on clk and the bank samples irq_ack on clk
`timescale 1ns/10ps
module core_ack_model (
    input  wire logic                  clk,      // system clock
    input  wire logic                  rst,      // synchronous reset
    input  wire irq_bank_pkg::irq_out_t irq_out, // request from the bank
    input  wire logic                  ack_en,   // servicing allowed
    input  wire logic [3:0]            ack_wait, // cycles before taking
    output logic                       irq_ack   // one-cycle acknowledge
);
    import irq_bank_pkg::*;

    logic [3:0] wait_cnt; // cycles the request has stood

    ////////////////////////////////////////////////////////////////////////
    // acknowledge: one pulse per service, only while a request stands
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            irq_ack  <= 1'b0;
        end else if (irq_ack || !irq_out.req || !ack_en) begin
            // no request or just taken: start counting afresh
            wait_cnt <= 4'h0;
            irq_ack  <= 1'b0;
        end else if (wait_cnt == ack_wait) begin
            irq_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : core_ack_model

// ===== bench/testbench.sv
// self-checking bench of the interrupt register bank against a model
// assumes the default variant: one external pin, no second group
`timescale 1ns/10ps
module testbench;
    import irq_bank_pkg::*;

    logic       clk = 1'b0; // system clock
    logic       rst;         // synchronous reset
    logic       clk_en;      // state advance
    logic [2:0] addr;        // register address
    logic [7:0] wdata;       // write data
    logic       wr_stb;      // write strobe
    logic       rd_stb;      // read strobe
    logic [7:0] rdata;       // read data
    logic       pin0_in;     // external pin 0
    logic       pin1_in;     // pin 1, ignored in this variant
    src_evt_t   events;      // source pulses
    logic       irq_ack;     // acknowledge from the core model
    irq_out_t   irq_out;     // request and vector
    logic       irq_line;    // overrun interrupt
    logic       ack_en;      // core may take requests
    logic [3:0] ack_wait;    // core response delay
    logic [7:0] mdl [0:7];   // reference register image
    int         errors;
    int         comparisons;
    int         seed;

    always #12.5 clk = ~clk;

    mcu_irq_register_bank u_mcu_irq_register_bank (
        .clk(clk), .rst(rst), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .pin0_in(pin0_in), .pin1_in(pin1_in), .events(events),
        .irq_ack(irq_ack), .irq_out(irq_out), .irq_line(irq_line));

    core_ack_model u_core_ack_model (
        .clk(clk), .rst(rst), .irq_out(irq_out), .ack_en(ack_en),
        .ack_wait(ack_wait), .irq_ack(irq_ack));

    ////////////////////////////////////////////////////////////////////////
    // comparison, verdict and register image helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // writable bits of each address; group 1 and address 7 hold none
    function automatic logic [7:0] wmask(input int a);
        case (a)
            0: return EDGE_MASK_1;
            1: return CTRL0_MASK;
            2: return CTRL1_MASK;
            3: return GRP_MASK;
            5, 6: return SRC_MASK;
            default: return 8'h00;
        endcase
    endfunction : wmask

    // register, flag bit and enable bit of source i
    function automatic int sreg(input int i);
        return (i < 3) ? 1 : 2;
    endfunction : sreg
    function automatic int fbit(input int i);
        return (i < 3) ? 4 + i : i + 1;
    endfunction : fbit
    function automatic int ebit(input int i);
        return (i < 3) ? 1 + i : i - 3;
    endfunction : ebit

    // lowest source with flag and enable both set, -1 if none
    function automatic int pend;
        for (int i = 0; i < 6; i++) begin
            if (mdl[sreg(i)][fbit(i)] && mdl[sreg(i)][ebit(i)]) return i;
        end
        return -1;
    endfunction : pend

    ////////////////////////////////////////////////////////////////////////
    // register port cycles, with a gap so strobes never double-assign
    task automatic wr(input int a, input logic [7:0] d);
        addr   <= a[2:0];
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        if (clk_en && a == 5) mdl[5] = mdl[5] & ~d;
        else if (clk_en) mdl[a] = d & wmask(a);
        @(posedge clk);
    endtask : wr

    task automatic rd(input int a);
        addr   <= a[2:0];
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        check(rdata, mdl[a]);
        @(negedge clk);
        check(rdata, 8'h00);
        @(posedge clk);
    endtask : rd

    // request, vector and overrun line against the image
    task automatic chk_irq;
        int p;
        p = pend();
        check({7'h0, irq_out.req}, {7'h0, p >= 0 && mdl[1][0]});
        if (p >= 0 && mdl[1][0]) check({5'h0, irq_out.vector}, 8'(p));
        check({7'h0, irq_line}, {7'h0, |(mdl[5] & mdl[6])});
    endtask : chk_irq

    // one-cycle event of source i; a flag already set counts as overrun
    task automatic pulse(input int i);
        src_evt_t e;
        e = '0;
        case (i)
            1: e.tb0 = 1'b1;
            2: e.tb1 = 1'b1;
            3: e.tm0 = 2'h3;
            4: e.eeprom = 1'b1;
            default: e.adc = 1'b1;
        endcase
        events <= e;
        @(posedge clk);
        events <= '0;
        if (i == 3) mdl[3][5:4] = 2'h3;
        if (i != 3 || mdl[3][1:0] != 2'h0) begin
            if (mdl[sreg(i)][fbit(i)]) mdl[5][i] = 1'b1;
            mdl[sreg(i)][fbit(i)] = 1'b1;
        end
        @(posedge clk);
    endtask : pulse

    // let the core take the request; global enable and flag drop
    task automatic service(input logic [3:0] w);
        int p;
        p = pend();
        ack_wait <= w;
        ack_en   <= 1'b1;
        for (int n = 0; n < 30 && irq_ack !== 1'b1; n++) @(posedge clk);
        ack_en <= 1'b0;
        check({7'h0, irq_ack}, 8'h01);
        mdl[1][0] = 1'b0;
        mdl[sreg(p)][fbit(p)] = 1'b0;
        @(posedge clk);
    endtask : service

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst <= 1'b1; clk_en <= 1'b1; addr <= 3'h0; wdata <= 8'h00;
        wr_stb <= 1'b0; rd_stb <= 1'b0; pin0_in <= 1'b0; pin1_in <= 1'b0;
        events <= '0; ack_en <= 1'b0; ack_wait <= 4'h0;
        errors = 0;
        comparisons = 0;
        seed = 61570;
        for (int a = 0; a < 8; a++) mdl[a] = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++) rd(a);
        for (int a = 0; a < 8; a++) begin
            wr(a, 8'hFF);
            rd(a);
        end
        for (int n = 0; n < 24; n++) begin
            int a;
            a = $random(seed) & 7;
            pin1_in <= 1'($random(seed));
            wr(a, 8'($random(seed)));
            rd(a);
            chk_irq;
        end
        clk_en <= 1'b0;
        wr(1, 8'h7F);
        clk_en <= 1'b1;
        rd(1);
        for (int a = 0; a < 7; a++) wr(a, (a == 5) ? 8'hFF : 8'h00);
        wr(6, 8'hFF);
        // every edge code: rise then fall
        for (int c = 0; c < 4; c++) begin
            wr(0, 8'(c));
            pin0_in <= 1'b1;
            repeat (5) @(posedge clk);
            mdl[1][4] = c[0];
            rd(1);
            wr(1, 8'h00);
            pin0_in <= 1'b0;
            repeat (5) @(posedge clk);
            mdl[1][4] = c[1];
            rd(1);
            wr(1, 8'h00);
        end
        // each internal source: flag, request, overrun except group 0, service
        for (int i = 1; i < 6; i++) begin
            wr(3, 8'h03);
            wr(sreg(i), 8'h01 << ebit(i));
            pulse(i);
            rd(sreg(i));
            chk_irq;
            wr(1, mdl[1] | 8'h01);
            chk_irq;
            if (i != 3) begin
                pulse(i);
                chk_irq;
                wr(5, 8'h7F);
                chk_irq;
            end
            service(4'(i));
            rd(1);
            pulse(i);
            rd(sreg(i));
            chk_irq;
            rd(3);
            wr(1, 8'h00);
            wr(2, 8'h00);
            wr(3, 8'h00);
        end
        finish_test;
    end

    // watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test;
    end
endmodule : testbench
